/* fap_regs.svh */
// Flash array protect/program control: register offsets, fields, reset values, timing counts.
// Assumes a plain register port with byte-wide data and 16-bit addresses.
`ifndef FAP_REGS_SVH
`define FAP_REGS_SVH

`define FAP_CTRL_ADDR       16'hFF88
`define FAP_PROT_ADDR       16'hFF80
`define FAP_PROT2_ADDR      16'hFF81
`define FAP_ARRAY_BASE      16'h8000
`define FAP_VECTOR_PAGE     9'h1FF
`define FAP_BIT_PGM         0
`define FAP_BIT_ERASE       1
`define FAP_BIT_MASS        2
`define FAP_BIT_HIGH_VOLTAGE_ENABLE        3
`define FAP_CTRL_RESET      8'h00
`define FAP_PROT_ERASED     8'hFF
`define FAP_PROT_FE         8'hFE
`define FAP_FE_START        16'hFF00
`define FAP_CLK_MHZ         200
`define FAP_NVS_NS          10000
`define FAP_NVS_CYC         ((`FAP_NVS_NS * `FAP_CLK_MHZ + 999) / 1000)
`define FAP_PGS_NS          5000
`define FAP_PGS_CYC         ((`FAP_PGS_NS * `FAP_CLK_MHZ + 999) / 1000)

`endif

/* fap_pkg.sv */
// Flash array protect/program control: shared types.
// Assumes fap_regs.svh supplies the numeric constants.
package fap_pkg;

    typedef enum logic [2:0] {
        FAP_IDLE,
        FAP_SELECTED,
        FAP_PROT_READ,
        FAP_LATCHED,
        FAP_HV_ON
    } fap_seq_e;

    typedef struct packed {
        logic high_voltage_enable;
        logic mass;
        logic erase;
        logic program_select;
    } fap_ctrl_s;

    typedef struct packed {
        logic        wr;
        logic [15:0] addr;
        logic [7:0]  data;
    } fap_arr_req_s;

endpackage

/* fap_protect.sv */
// Protection window decode from the protect byte.
// Assumes the protect byte is stable while HV is requested.
`timescale 1ns/1ps
`default_nettype none
`include "fap_regs.svh"

module fap_protect
    import fap_pkg::*;
(
    // Inputs
    input  wire logic [7:0]  prot_byte,
    input  wire logic [15:0] addr,
    // Results
    output logic [15:0]      start_addr,
    output logic             addr_protected,
    output logic             any_protect
);

    always_comb
    begin
        if (prot_byte == `FAP_PROT_FE)
            start_addr = `FAP_FE_START;
        else
            start_addr = {1'b1, prot_byte, 7'h00};
        any_protect = (prot_byte != `FAP_PROT_ERASED);
        addr_protected = any_protect && (addr >= start_addr);
    end

endmodule
`default_nettype wire

/* fap_ctrl.sv */
// Flash array control register, sequence tracking and array write gating.
// Assumes the CPU drives the register port synchronously with SYS_CLK.
//
// The address map and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "fap_regs.svh"

module fap_ctrl
    import fap_pkg::*;
(
    // Clock and reset
    input  wire logic        SYS_CLK,
    input  wire logic        RESET,
    // Register and array port
    input  wire logic [15:0] ADDR,
    input  wire logic [7:0]  WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic [7:0]       RDATA,
    // Array read data and the protect byte from the cells
    input  wire logic [7:0]  ARRAY_RDATA,
    input  wire logic [7:0]  PROT_BYTE,
    // Low power entry
    input  wire logic        LOW_POWER,
    // Array operation controls
    output logic             CHARGE_PUMP_ON,
    output logic             ARRAY_PROG,
    output logic             ARRAY_PAGE_ERASE,
    output logic             ARRAY_MASS_ERASE,
    output logic             PROT_BYTES_ERASE,
    output logic             ROW_FAIL,
    output logic [15:0]      LATCH_ADDR,
    output logic             BYTE_WR,
    output logic [15:0]      BYTE_ADDR,
    output logic [7:0]       BYTE_DATA
);

    fap_ctrl_s      ctrl_reg, ctrl_next;
    fap_seq_e       seq_reg, seq_next;
    logic [15:0]    latch_reg, latch_next;
    logic [15:0]    cnt_reg, cnt_next;
    logic           fail_reg, fail_next;
    logic           bwr_reg, bwr_next;
    logic [15:0]    baddr_reg, baddr_next;
    logic [7:0]     bdata_reg, bdata_next;
    logic [7:0]     rdata_reg, rdata_next;
    logic           prot_hit;
    logic           any_prot;
    logic [15:0]    prot_start;
    logic           ctrl_wr;
    logic           arr_wr;
    logic           in_array;
    fap_ctrl_s      wctrl;

    fap_protect u_protect (
        .prot_byte      (PROT_BYTE),
        .addr           (latch_reg),
        .start_addr     (prot_start),
        .addr_protected (prot_hit),
        .any_protect    (any_prot)
    );

    assign in_array = (ADDR >= `FAP_ARRAY_BASE) && (ADDR != `FAP_CTRL_ADDR);
    assign ctrl_wr  = WR && (ADDR == `FAP_CTRL_ADDR);
    assign arr_wr   = WR && in_array;
    assign wctrl    = fap_ctrl_s'(WDATA[3:0]);

    // Control register and sequence state
    always_comb
    begin
        ctrl_next  = ctrl_reg;
        seq_next   = seq_reg;
        latch_next = latch_reg;
        cnt_next   = (cnt_reg != 16'h0000) ? cnt_reg - 16'h0001 : cnt_reg;
        fail_next  = fail_reg;
        bwr_next   = 1'b0;
        baddr_next = baddr_reg;
        bdata_next = bdata_reg;
        if (LOW_POWER)
        begin
            ctrl_next = fap_ctrl_s'(4'(`FAP_CTRL_RESET));
            seq_next  = FAP_IDLE;
            cnt_next  = 16'h0000;
        end
        else if (ctrl_wr)
        begin
            if (!(wctrl.program_select && wctrl.erase))
            begin
                ctrl_next.program_select   = wctrl.program_select;
                ctrl_next.erase = wctrl.erase;
                ctrl_next.mass  = wctrl.mass;
                if (!wctrl.high_voltage_enable)
                    ctrl_next.high_voltage_enable = 1'b0;
                else if (!ctrl_reg.high_voltage_enable && (wctrl.program_select || wctrl.erase)
                         && seq_reg == FAP_LATCHED && cnt_reg == 16'h0000
                         && !prot_hit
                         && !(wctrl.erase && wctrl.mass && any_prot))
                begin
                    ctrl_next.high_voltage_enable = 1'b1;
                    seq_next = FAP_HV_ON;
                    cnt_next = 16'(`FAP_PGS_CYC);
                end
                if (!wctrl.program_select && !wctrl.erase && !ctrl_next.high_voltage_enable)
                    seq_next = FAP_IDLE;
                else if ((wctrl.program_select != ctrl_reg.program_select || wctrl.erase != ctrl_reg.erase)
                         && !ctrl_reg.high_voltage_enable)
                begin
                    seq_next  = FAP_SELECTED;
                    fail_next = 1'b0;
                end
            end
        end
        else if (RD && ADDR == `FAP_PROT_ADDR && seq_reg == FAP_SELECTED)
            seq_next = FAP_PROT_READ;
        else if (arr_wr && (ctrl_reg.program_select || ctrl_reg.erase))
        begin
            if (seq_reg == FAP_PROT_READ)
            begin
                latch_next = ADDR;
                seq_next   = FAP_LATCHED;
                cnt_next   = 16'(`FAP_NVS_CYC);
            end
            else if (seq_reg == FAP_HV_ON && ctrl_reg.program_select && ctrl_reg.high_voltage_enable)
            begin
                if (ADDR[15:6] != latch_reg[15:6] || cnt_reg != 16'h0000)
                    fail_next = 1'b1;
                else
                begin
                    bwr_next   = 1'b1;
                    baddr_next = ADDR;
                    bdata_next = WDATA;
                end
            end
        end
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (RESET)
        begin
            ctrl_reg  <= fap_ctrl_s'(4'(`FAP_CTRL_RESET));
            seq_reg   <= FAP_IDLE;
            latch_reg <= 16'h0000;
            cnt_reg   <= 16'h0000;
            fail_reg  <= 1'b0;
            bwr_reg   <= 1'b0;
            baddr_reg <= 16'h0000;
            bdata_reg <= 8'h00;
        end
        else
        begin
            ctrl_reg  <= ctrl_next;
            seq_reg   <= seq_next;
            latch_reg <= latch_next;
            cnt_reg   <= cnt_next;
            fail_reg  <= fail_next;
            bwr_reg   <= bwr_next;
            baddr_reg <= baddr_next;
            bdata_reg <= bdata_next;
        end
    end

    // Read data, one cycle after the strobe
    always_comb
    begin
        rdata_next = 8'h00;
        if (RD)
        begin
            if (ADDR == `FAP_CTRL_ADDR)
                rdata_next = {4'h0, ctrl_reg};
            else if (ADDR == `FAP_PROT_ADDR)
                rdata_next = PROT_BYTE;
            else if (in_array)
                rdata_next = ARRAY_RDATA;
        end
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (RESET)
            rdata_reg <= 8'h00;
        else
            rdata_reg <= rdata_next;
    end

    assign RDATA            = rdata_reg;
    assign CHARGE_PUMP_ON   = ctrl_reg.high_voltage_enable;
    assign ARRAY_PROG       = ctrl_reg.high_voltage_enable && ctrl_reg.program_select;
    assign ARRAY_PAGE_ERASE = ctrl_reg.high_voltage_enable && ctrl_reg.erase && !ctrl_reg.mass;
    assign ARRAY_MASS_ERASE = ctrl_reg.high_voltage_enable && ctrl_reg.erase && ctrl_reg.mass;
    assign PROT_BYTES_ERASE = ctrl_reg.high_voltage_enable && ctrl_reg.erase
                              && (ctrl_reg.mass || latch_reg[15:7] == `FAP_VECTOR_PAGE);
    assign ROW_FAIL         = fail_reg;
    assign LATCH_ADDR       = latch_reg;
    assign BYTE_WR          = bwr_reg;
    assign BYTE_ADDR        = baddr_reg;
    assign BYTE_DATA        = bdata_reg;

    // Checks
    property p_interlock;
        @(posedge SYS_CLK) disable iff (RESET)
        !(ctrl_reg.program_select && ctrl_reg.erase);
    endproperty
    a_interlock: assert property (p_interlock) else $error("pgm and erase both set");

    property p_no_hv_protected;
        @(posedge SYS_CLK) disable iff (RESET)
        $rose(ctrl_reg.high_voltage_enable) |-> !$past(prot_hit);
    endproperty
    a_no_hv_protected: assert property (p_no_hv_protected) else $error("hv on protected");

    property p_no_mass_protected;
        @(posedge SYS_CLK) disable iff (RESET)
        (ctrl_reg.high_voltage_enable && ctrl_reg.mass && ctrl_reg.erase) |-> !any_prot;
    endproperty
    a_no_mass_protected: assert property (p_no_mass_protected) else $error("mass erase");

    property p_hv_needs_select;
        @(posedge SYS_CLK) disable iff (RESET)
        $rose(ctrl_reg.high_voltage_enable) |-> ($past(seq_reg) == FAP_LATCHED);
    endproperty
    a_hv_needs_select: assert property (p_hv_needs_select) else $error("hv out of order");

    property p_low_power;
        @(posedge SYS_CLK) disable iff (RESET)
        LOW_POWER |=> (ctrl_reg == fap_ctrl_s'(4'h0)) && !CHARGE_PUMP_ON;
    endproperty
    a_low_power: assert property (p_low_power) else $error("low power not standby");

    property p_ignore_idle_write;
        @(posedge SYS_CLK) disable iff (RESET)
        (arr_wr && !ctrl_reg.program_select && !ctrl_reg.erase) |=> !BYTE_WR && $stable(latch_reg);
    endproperty
    a_ignore_idle_write: assert property (p_ignore_idle_write) else $error("idle write");

    property p_row;
        @(posedge SYS_CLK) disable iff (RESET)
        BYTE_WR |-> (BYTE_ADDR[15:6] == latch_reg[15:6]);
    endproperty
    a_row: assert property (p_row) else $error("byte outside row");

    property p_start;
        @(posedge SYS_CLK) disable iff (RESET)
        (PROT_BYTE == 8'h00) |-> (prot_start == 16'h8000) && (prot_hit == (latch_reg >= 16'h8000));
    endproperty
    a_start: assert property (p_start) else $error("zero protect start wrong");

    sequence s_hv_rise;
        !ctrl_reg.high_voltage_enable ##1 ctrl_reg.high_voltage_enable;
    endsequence

    property p_hv_setup;
        @(posedge SYS_CLK) disable iff (RESET)
        s_hv_rise |-> ($past(cnt_reg) == 16'h0000) && (ctrl_reg.program_select || ctrl_reg.erase);
    endproperty
    a_hv_setup: assert property (p_hv_setup) else $error("hv too early");

    property p_byte_setup;
        @(posedge SYS_CLK) disable iff (RESET)
        BYTE_WR |-> ARRAY_PROG && ($past(cnt_reg) == 16'h0000);
    endproperty
    a_byte_setup: assert property (p_byte_setup) else $error("byte before setup");

endmodule
`default_nettype wire

/* fap_cells_model.sv */
// Flash cell model: protect byte and one row of array bytes.
// Assumes the bench sets the protect value and the control block drives byte writes.
`timescale 1ns/1ps
`default_nettype none

module fap_cells_model
(
    // Clock and bench setting
    input  wire logic        clk,
    input  wire logic [7:0]  prot_value,
    // Control block side
    input  wire logic [15:0] addr,
    input  wire logic        byte_wr,
    input  wire logic [15:0] byte_addr,
    input  wire logic [7:0]  byte_data,
    input  wire logic        page_erase,
    input  wire logic        pump_on,
    output logic [7:0]       prot_byte,
    output logic [7:0]       array_rdata
);
    logic [7:0] mem [64];

    initial
    begin
        for (int i = 0; i < 64; i++)
            mem[i] = 8'hFF;
    end

    always @(posedge clk)
    begin
        if (page_erase && pump_on)
            for (int i = 0; i < 64; i++)
                mem[i] <= 8'hFF;
        else if (byte_wr)
            mem[byte_addr[5:0]] <= mem[byte_addr[5:0]] & byte_data;
    end

    assign prot_byte   = prot_value;
    assign array_rdata = mem[addr[5:0]];
endmodule
`default_nettype wire

/* tb_flash_array_protect_and_program_control.sv */
// Testbench for the flash array control block.
// Assumes fap_pkg, fap_regs.svh, the design and the cell model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "fap_regs.svh"

module tb_flash_array_protect_and_program_control
    import fap_pkg::*;
;
    logic        sys_clk, reset, wr, rd, low_power;
    logic [15:0] addr;
    logic [7:0]  wdata, prot_value, rdata, array_rdata, prot_byte, d;
    logic        pump, prog, page_er, mass_er, prot_er, row_fail, byte_wr;
    logic [15:0] latch_addr, byte_addr;
    logic [7:0]  byte_data;
    int          fails, checks, wr_pulses;
    logic [7:0]  pt [10] = '{8'hFF, 8'hFE, 8'hFE, 8'hFD, 8'hFD, 8'h00, 8'h01, 8'h01, 8'h0A, 8'h0A};
    logic [15:0] at [10] = '{16'hFFC0, 16'hFEFF, 16'hFF00, 16'hFE7F, 16'hFE80,
                             16'h8000, 16'h807F, 16'h8080, 16'h8500, 16'h84FF};

    fap_ctrl dut (.SYS_CLK(sys_clk), .RESET(reset), .ADDR(addr), .WDATA(wdata), .WR(wr),
        .RD(rd), .RDATA(rdata), .ARRAY_RDATA(array_rdata), .PROT_BYTE(prot_byte),
        .LOW_POWER(low_power), .CHARGE_PUMP_ON(pump), .ARRAY_PROG(prog),
        .ARRAY_PAGE_ERASE(page_er), .ARRAY_MASS_ERASE(mass_er), .PROT_BYTES_ERASE(prot_er),
        .ROW_FAIL(row_fail), .LATCH_ADDR(latch_addr), .BYTE_WR(byte_wr),
        .BYTE_ADDR(byte_addr), .BYTE_DATA(byte_data));

    fap_cells_model cells (.clk(sys_clk), .prot_value(prot_value), .addr(addr),
        .byte_wr(byte_wr), .byte_addr(byte_addr), .byte_data(byte_data),
        .page_erase(page_er), .pump_on(pump), .prot_byte(prot_byte),
        .array_rdata(array_rdata));

    initial
    begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk)
        if (byte_wr === 1'b1)
            wr_pulses++;

    task automatic final_report();
        if (fails == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic bus_wr(input logic [15:0] a, input logic [7:0] v);
        @(posedge sys_clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge sys_clk);
        wr <= 1'b0;
        #1;
    endtask

    task automatic bus_rd(input logic [15:0] a, output logic [7:0] v);
        @(posedge sys_clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge sys_clk);
        rd <= 1'b0;
        #1;
        v = rdata;
    endtask

    function automatic logic prot_ok(input logic [7:0] p, input logic [15:0] a);
        return (p == 8'hFF) || (a < {1'b1, p, 7'h00});
    endfunction

    // Select, optional protect read, latch, wait, then request high voltage
    task automatic op(input logic [7:0] p, input logic [7:0] sel, input logic [15:0] a,
                      input logic rdp, input int w, input logic ok);
        logic [7:0] v;
        @(posedge sys_clk);
        prot_value <= p;
        bus_wr(`FAP_CTRL_ADDR, sel);
        if (rdp)
        begin
            bus_rd(`FAP_PROT_ADDR, v);
            check("prot_read", v, p);
        end
        bus_wr(a, 8'h5A);
        cyc(w);
        bus_wr(`FAP_CTRL_ADDR, sel | 8'h08);
        check("pump", pump, ok);
    endtask

    task automatic op_end(input int h);
        bus_wr(`FAP_CTRL_ADDR, 8'h08);
        cyc(h);
        bus_wr(`FAP_CTRL_ADDR, 8'h00);
        check("pump_off", pump, 1'b0);
    endtask

    initial
    begin
        #(5 * 90000);
        fails++;
        final_report();
    end

    initial
    begin
        {reset, wr, rd, low_power} = 4'h8;
        addr = 16'h0000;
        wdata = 8'h00;
        prot_value = 8'hFF;
        repeat (10) @(posedge sys_clk);
        reset <= 1'b0;
        bus_rd(`FAP_CTRL_ADDR, d);
        check("ctrl_reset", d, `FAP_CTRL_RESET);
        bus_wr(16'h8000, 8'h00);
        check("latch_idle", latch_addr, 16'h0000);
        bus_wr(`FAP_CTRL_ADDR, 8'h03);
        bus_rd(`FAP_CTRL_ADDR, d);
        check("both_sel", d, 8'h00);
        check("prog_idle", prog, 1'b0);
        for (int i = 0; i < 10; i++)
        begin
            op(pt[i], 8'h01, at[i], 1'b1, 2005, prot_ok(pt[i], at[i]));
            op_end(1005);
        end
        op(8'hFF, 8'h01, 16'h8040, 1'b1, 100, 1'b0);
        op_end(1005);
        op(8'hFF, 8'h01, 16'h8040, 1'b0, 2005, 1'b0);
        op_end(1005);
        op(8'hFF, 8'h01, 16'h8040, 1'b1, 2005, 1'b1);
        check("prog", prog, 1'b1);
        cyc(1005);
        bus_wr(16'h8041, 8'hAA);
        check("byte_wr", byte_wr, 1'b1);
        check("byte_addr", byte_addr, 16'h8041);
        check("byte_data", byte_data, 8'hAA);
        check("row_ok", row_fail, 1'b0);
        cyc(6005);
        bus_wr(16'h8080, 8'h00);
        check("row_fail", row_fail, 1'b1);
        op_end(1005);
        check("pulses", wr_pulses == 1, 1'b1);
        cyc(205);
        bus_rd(16'h8041, d);
        check("array_read", d, 8'hAA);
        op(8'hFF, 8'h06, 16'h8123, 1'b1, 2005, 1'b1);
        check("mass", mass_er, 1'b1);
        check("prot_er_mass", prot_er, 1'b1);
        op_end(20005);
        op(8'hFE, 8'h06, 16'h8000, 1'b1, 2005, 1'b0);
        op_end(1005);
        op(8'hFF, 8'h02, 16'hFF90, 1'b1, 2005, 1'b1);
        check("prot_er_page", prot_er, 1'b1);
        op_end(1005);
        op(8'hFF, 8'h02, 16'h8000, 1'b1, 2005, 1'b1);
        check("page", page_er, 1'b1);
        check("no_mass", mass_er, 1'b0);
        check("prot_er_low", prot_er, 1'b0);
        @(posedge sys_clk);
        low_power <= 1'b1;
        cyc(2);
        check("lp_pump", pump, 1'b0);
        check("lp_page", page_er, 1'b0);
        @(posedge sys_clk);
        low_power <= 1'b0;
        bus_rd(`FAP_CTRL_ADDR, d);
        check("lp_ctrl", d, 8'h00);
        final_report();
    end
endmodule
`default_nettype wire
